// ---- hdl/hsc_params.svh ----
// constants for the homing sequence controller
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define HSC_OFS_CONFIG 8'h00
`define HSC_OFS_COMMAND 8'h04
`define HSC_OFS_POINT 8'h08
`define HSC_OFS_STATUS 8'h0C
`define HSC_OFS_INT_STAT 8'h10
`define HSC_OFS_INT_MASK 8'h14
`define HSC_OFS_TORQUE 8'h18
`define HSC_OFS_CREEP 8'h1C
// ----------------------------------------
// reset values
// ----------------------------------------
`define HSC_CONFIG_RST 16'h0019
`define HSC_TORQUE_RST 12'h1F4
`define HSC_CREEP_RST 16'h000A
// ----------------------------------------
// config field positions
// ----------------------------------------
`define HSC_CFG_PT_LO 0
`define HSC_CFG_REF_LO 2
`define HSC_CFG_INDEX 4
`define HSC_CFG_DIR 5
`define HSC_CFG_TQSW 6
`define HSC_CFG_CREEP 7
`define HSC_CFG_CTLMODE_LO 8
`define HSC_CFG_CMDMODE_LO 12
// ----------------------------------------
// command bits, setting codes
// ----------------------------------------
`define HSC_CMD_START 0
`define HSC_CMD_ABORT 1
`define HSC_PT_ON_START 2'h0
`define HSC_PT_ON_DONE 2'h1
`define HSC_PT_EACH 2'h2
`define HSC_REF_USER 2'h0
`define HSC_REF_STOPPER 2'h1
`define HSC_REF_DOG 2'h2
`define HSC_CTLMODE_POS 4'h0
`define HSC_CMDMODE_INT 4'h3
// ----------------------------------------
// interrupt bits, bus answers
// ----------------------------------------
`define HSC_INT_HOMED 0
`define HSC_INT_POINT 1
`define HSC_RESP_OKAY 2'h0
`define HSC_RESP_SLVERR 2'h2
// ----------------------------------------
// synchronised pin indices
// ----------------------------------------
`define HSC_PIN_DOG 0
`define HSC_PIN_INDEX 1
`define HSC_PIN_STOPPER 2
`define HSC_PIN_SEQSTART 3
`define HSC_PIN_PTSTART 4
`define HSC_PIN_PTDONE 5
`define HSC_PIN_STOPPED 6
`define HSC_PIN_SHIFTDONE 7
`define HSC_PIN_COUNT 8
`endif

// ---- hdl/hsc_pkg.sv ----
// types shared by the homing sequence controller
`include "hsc_params.svh"
package hsc_pkg;
  typedef enum logic [2:0] {
    HSC_IDLE = 3'b000,
    HSC_LEAVE_DOG = 3'b001,
    HSC_SEEK_REF = 3'b010,
    HSC_SEEK_INDEX = 3'b011,
    HSC_DECEL = 3'b100,
    HSC_CREEP = 3'b101,
    HSC_FINISH = 3'b110,
    HSC_DONE = 3'b111
  } hsc_home_state_t;

  typedef struct packed {
    hsc_home_state_t st;
    logic [15:0] cfg;
    logic [2:0] pointReg;
    logic [2:0] pointOut;
    logic homingEnd;
    logic motionEnd;
    logic moveEn;
    logic moveCw;
    logic creepSel;
    logic torqueLimEn;
    logic [1:0] intStat;
    logic [1:0] intMask;
    logic irq;
    logic [11:0] torqueLimit;
    logic [15:0] creepSpeed;
    logic [`HSC_PIN_COUNT-1:0] pinsPrev;
    logic awGot;
    logic wGot;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsc_regs_t;
endpackage

// ---- hdl/hsc_sync2.sv ----
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module hsc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } hsc_sync_t;

  hsc_sync_t s_ff;
  hsc_sync_t nxt_s;

  // the first stage feeds only the second one
  always_comb begin
    nxt_s = s_ff;
    nxt_s.stage1 = din;
    nxt_s.stage2 = s_ff.stage1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.stage2;
endmodule

// ---- hdl/hsc_homing_ctrl.sv ----
// homing sequencer with point-number output timing and AXI4-Lite registers
//
// Summary of operation
// - point number is shown on motion start, motion complete, or each point start; default complete
// - point output timing acts only in position control with internal option-I/O command
// - home reference is user position, stopper, or dog front edge; default dog
// - index selection 1 uses first index pulse after reference; 0 ignores index
// - homing moves counterclockwise for setting 0 and clockwise for setting 1
// - starting on the dog, move backward and take the front edge on leaving
// - homing torque limit only when torque switch is 1 or reference is stopper; default off
// - stopper homing always limits torque to the homing limit value
// - creep off: stop after reference, home equals reference, both end outputs close
// - creep on: stop, creep by shift amount, then homing end, then motion end
// - slow approach runs at the creep speed, default 10 rpm
`timescale 1ns/1ps
`include "hsc_params.svh"
module hsc_homing_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic homeDog,
  input wire logic encoderIndex,
  input wire logic stopperPressed,
  input wire logic motionSeqStart,
  input wire logic pointMotionStart,
  input wire logic pointMotionComplete,
  input wire logic motorStopped,
  input wire logic shiftDone,
  output logic [2:0] pointNumberOut,
  output logic motionEndOutput,
  output logic homingEndOutput,
  output logic moveEnable,
  output logic moveCw,
  output logic creepSelect,
  output logic [15:0] creepSpeed,
  output logic torqueLimitEnable,
  output logic [11:0] torqueLimitValue,
  output logic irq
);
  import hsc_pkg::*;

  hsc_regs_t s_ff;
  hsc_regs_t nxt_s;
  logic [`HSC_PIN_COUNT-1:0] pins;
  logic [`HSC_PIN_COUNT-1:0] rise;
  logic [`HSC_PIN_COUNT-1:0] fall;
  logic [1:0] cfgPt;
  logic [1:0] cfgRef;
  logic cfgIndex;
  logic cfgDir;
  logic cfgTqSw;
  logic cfgCreep;
  logic ptGate;
  logic wrFire;
  logic rdFire;
  logic refDone;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  hsc_sync2 #(.WIDTH(`HSC_PIN_COUNT)) u_sync (
    .clock(clock),
    .rst(rst),
    .din({shiftDone, motorStopped, pointMotionComplete, pointMotionStart,
          motionSeqStart, stopperPressed, encoderIndex, homeDog}),
    .dout(pins)
  );

  assign rise = pins & ~s_ff.pinsPrev;
  assign fall = ~pins & s_ff.pinsPrev;
  assign cfgPt = s_ff.cfg[`HSC_CFG_PT_LO +: 2];
  assign cfgRef = s_ff.cfg[`HSC_CFG_REF_LO +: 2];
  assign cfgIndex = s_ff.cfg[`HSC_CFG_INDEX];
  assign cfgDir = s_ff.cfg[`HSC_CFG_DIR];
  assign cfgTqSw = s_ff.cfg[`HSC_CFG_TQSW];
  assign cfgCreep = s_ff.cfg[`HSC_CFG_CREEP];
  assign ptGate = (s_ff.cfg[`HSC_CFG_CTLMODE_LO +: 4] == `HSC_CTLMODE_POS) &&
                  (s_ff.cfg[`HSC_CFG_CMDMODE_LO +: 4] == `HSC_CMDMODE_INT);
  assign wrFire = s_ff.awGot && s_ff.wGot && !s_ff.bvalid;
  assign rdFire = arvalid && !s_ff.rvalid;

  function automatic logic [31:0] strobed(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `HSC_OFS_CREEP);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [1:0] ev;
    logic [1:0] clr;
    logic startCmd;
    logic abortCmd;
    wv = '0;
    ev = '0;
    clr = '0;
    startCmd = 1'b0;
    abortCmd = 1'b0;
    refDone = 1'b0;
    nxt_s = s_ff;
    nxt_s.pinsPrev = pins;

    // write channel: address and data taken in either order
    if (awvalid && !s_ff.awGot) begin
      nxt_s.awGot = 1'b1;
      nxt_s.awAddr = awaddr;
    end
    if (wvalid && !s_ff.wGot) begin
      nxt_s.wGot = 1'b1;
      nxt_s.wData = wdata;
      nxt_s.wStrb = wstrb;
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (wrFire) begin
      nxt_s.awGot = 1'b0;
      nxt_s.wGot = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = mapped(s_ff.awAddr) ? `HSC_RESP_OKAY : `HSC_RESP_SLVERR;
      unique case (s_ff.awAddr)
        `HSC_OFS_CONFIG: begin
          wv = strobed({16'h0000, s_ff.cfg}, s_ff.wData, s_ff.wStrb);
          nxt_s.cfg = wv[15:0];
        end
        `HSC_OFS_COMMAND: begin
          startCmd = s_ff.wStrb[0] && s_ff.wData[`HSC_CMD_START];
          abortCmd = s_ff.wStrb[0] && s_ff.wData[`HSC_CMD_ABORT];
        end
        `HSC_OFS_POINT: begin
          wv = strobed({29'h0, s_ff.pointReg}, s_ff.wData, s_ff.wStrb);
          nxt_s.pointReg = wv[2:0];
        end
        `HSC_OFS_INT_STAT: clr = s_ff.wStrb[0] ? s_ff.wData[1:0] : 2'h0;
        `HSC_OFS_INT_MASK: begin
          wv = strobed({30'h0, s_ff.intMask}, s_ff.wData, s_ff.wStrb);
          nxt_s.intMask = wv[1:0];
        end
        `HSC_OFS_TORQUE: begin
          wv = strobed({20'h0, s_ff.torqueLimit}, s_ff.wData, s_ff.wStrb);
          nxt_s.torqueLimit = wv[11:0];
        end
        `HSC_OFS_CREEP: begin
          wv = strobed({16'h0, s_ff.creepSpeed}, s_ff.wData, s_ff.wStrb);
          nxt_s.creepSpeed = wv[15:0];
        end
        default: ;
      endcase
    end

    // read channel: one cycle from address to data
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rdFire) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = mapped(araddr) ? `HSC_RESP_OKAY : `HSC_RESP_SLVERR;
      unique case (araddr)
        `HSC_OFS_CONFIG: nxt_s.rdata = {16'h0000, s_ff.cfg};
        `HSC_OFS_POINT: nxt_s.rdata = {29'h0, s_ff.pointReg};
        `HSC_OFS_STATUS: nxt_s.rdata = {21'h0, s_ff.pointOut, s_ff.torqueLimEn,
                                        s_ff.moveEn, s_ff.motionEnd, s_ff.homingEnd,
                                        s_ff.moveCw, s_ff.st};
        `HSC_OFS_INT_STAT: nxt_s.rdata = {30'h0, s_ff.intStat};
        `HSC_OFS_INT_MASK: nxt_s.rdata = {30'h0, s_ff.intMask};
        `HSC_OFS_TORQUE: nxt_s.rdata = {20'h0, s_ff.torqueLimit};
        `HSC_OFS_CREEP: nxt_s.rdata = {16'h0, s_ff.creepSpeed};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------
    // point number output
    // ----------------------------------------
    // gated by control modes
    if (!ptGate) begin
      nxt_s.pointOut = 3'h0;
    end else begin
      if ((cfgPt == `HSC_PT_ON_START && rise[`HSC_PIN_SEQSTART]) ||
          (cfgPt == `HSC_PT_ON_DONE && rise[`HSC_PIN_PTDONE]) ||
          (cfgPt == `HSC_PT_EACH && rise[`HSC_PIN_PTSTART])) begin
        nxt_s.pointOut = s_ff.pointReg;
        ev[`HSC_INT_POINT] = 1'b1;
      end
    end

    // ----------------------------------------
    // homing sequencer
    // ----------------------------------------
    unique case (s_ff.st)
      HSC_IDLE, HSC_DONE: begin
        if (startCmd) begin
          nxt_s.homingEnd = 1'b0;
          nxt_s.motionEnd = 1'b0;
          nxt_s.creepSel = 1'b0;
          nxt_s.moveEn = 1'b1;
          nxt_s.moveCw = cfgDir;
          if (cfgRef == `HSC_REF_USER) begin
            refDone = 1'b1;
          end else if (cfgRef == `HSC_REF_DOG && pins[`HSC_PIN_DOG]) begin
            // start on dog, back off first
            nxt_s.st = HSC_LEAVE_DOG;
            nxt_s.moveCw = !cfgDir;
          end else begin
            nxt_s.st = HSC_SEEK_REF;
          end
        end
      end
      HSC_LEAVE_DOG: begin
        // front edge seen when leaving dog
        refDone = fall[`HSC_PIN_DOG];
      end
      HSC_SEEK_REF: begin
        refDone = (cfgRef == `HSC_REF_STOPPER) ? rise[`HSC_PIN_STOPPER] :
                  rise[`HSC_PIN_DOG];
      end
      HSC_SEEK_INDEX: begin
        if (rise[`HSC_PIN_INDEX]) begin
          nxt_s.st = HSC_DECEL;
          nxt_s.moveEn = 1'b0;
        end
      end
      HSC_DECEL: begin
        if (pins[`HSC_PIN_STOPPED]) begin
          if (cfgCreep) begin
            nxt_s.st = HSC_CREEP;
            nxt_s.moveEn = 1'b1;
            nxt_s.creepSel = 1'b1;
            nxt_s.moveCw = cfgDir;
          end else begin
            // home is the reference, both ends close
            nxt_s.st = HSC_DONE;
            nxt_s.homingEnd = 1'b1;
            nxt_s.motionEnd = 1'b1;
            ev[`HSC_INT_HOMED] = 1'b1;
          end
        end
      end
      HSC_CREEP: begin
        // homing end closes before motion end
        if (rise[`HSC_PIN_SHIFTDONE]) begin
          nxt_s.st = HSC_FINISH;
          nxt_s.moveEn = 1'b0;
          nxt_s.creepSel = 1'b0;
          nxt_s.homingEnd = 1'b1;
        end
      end
      HSC_FINISH: begin
        nxt_s.st = HSC_DONE;
        nxt_s.motionEnd = 1'b1;
        ev[`HSC_INT_HOMED] = 1'b1;
      end
    endcase

    // index selection decides the next step
    if (refDone) begin
      if (cfgIndex) begin
        nxt_s.st = HSC_SEEK_INDEX;
      end else begin
        nxt_s.st = HSC_DECEL;
        nxt_s.moveEn = 1'b0;
      end
    end

    if (abortCmd) begin
      nxt_s.st = HSC_IDLE;
      nxt_s.moveEn = 1'b0;
      nxt_s.creepSel = 1'b0;
    end

    // switch enables limit; stopper always limits
    nxt_s.torqueLimEn = (nxt_s.st != HSC_IDLE) && (nxt_s.st != HSC_DONE) &&
                        (cfgTqSw || cfgRef == `HSC_REF_STOPPER);

    // set wins over a clear in the same cycle
    nxt_s.intStat = (s_ff.intStat & ~clr) | ev;
    nxt_s.irq = |(nxt_s.intStat & nxt_s.intMask);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.st <= HSC_IDLE;
      s_ff.cfg <= `HSC_CONFIG_RST;
      s_ff.torqueLimit <= `HSC_TORQUE_RST;
      s_ff.creepSpeed <= `HSC_CREEP_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign awready = !s_ff.awGot;
  assign wready = !s_ff.wGot;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign arready = !s_ff.rvalid;
  assign rvalid = s_ff.rvalid;
  assign rdata = s_ff.rdata;
  assign rresp = s_ff.rresp;
  assign pointNumberOut = s_ff.pointOut;
  assign motionEndOutput = s_ff.motionEnd;
  assign homingEndOutput = s_ff.homingEnd;
  assign moveEnable = s_ff.moveEn;
  assign moveCw = s_ff.moveCw;
  assign creepSelect = s_ff.creepSel;
  assign creepSpeed = s_ff.creepSpeed;
  assign torqueLimitEnable = s_ff.torqueLimEn;
  assign torqueLimitValue = s_ff.torqueLimit;
  assign irq = s_ff.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic abortCmdSeen;
  assign abortCmdSeen = wrFire && s_ff.awAddr == `HSC_OFS_COMMAND &&
                        s_ff.wData[`HSC_CMD_ABORT];

  sequence creepEndSeq;
    s_ff.st == HSC_CREEP && rise[`HSC_PIN_SHIFTDONE] && !abortCmdSeen;
  endsequence
  sequence endOrderSeq;
    ##1 (s_ff.homingEnd && !s_ff.motionEnd) ##1 (s_ff.homingEnd && s_ff.motionEnd);
  endsequence

  pt_done_latch_a: assert property (ptGate && cfgPt == `HSC_PT_ON_DONE &&
    rise[`HSC_PIN_PTDONE] |=> pointNumberOut == $past(s_ff.pointReg))
    else $error("point number not shown on motion complete");
  pt_gate_a: assert property (!ptGate |=> pointNumberOut == 3'h0)
    else $error("point output active outside position internal mode");
  user_ref_a: assert property ($rose(s_ff.moveEn) && $past(cfgRef) == `HSC_REF_USER &&
    $past(cfgIndex) && !s_ff.creepSel |-> s_ff.st == HSC_SEEK_INDEX)
    else $error("user position reference did not go to index search");
  index_skip_a: assert property (s_ff.st == HSC_SEEK_REF && !cfgIndex && refDone &&
    !abortCmdSeen |=> s_ff.st == HSC_DECEL && !s_ff.moveEn)
    else $error("reference without index did not stop");
  seek_dir_a: assert property (s_ff.st == HSC_SEEK_REF |-> s_ff.moveCw == cfgDir)
    else $error("seek direction differs from setting");
  leave_dog_a: assert property (s_ff.st == HSC_LEAVE_DOG |->
    s_ff.moveEn && s_ff.moveCw == !cfgDir)
    else $error("leaving dog not in reverse direction");
  torque_off_a: assert property (!cfgTqSw && cfgRef != `HSC_REF_STOPPER &&
    $stable(s_ff.cfg) |=> !torqueLimitEnable)
    else $error("torque limited while switch is off");
  stopper_torque_a: assert property (cfgRef == `HSC_REF_STOPPER &&
    $stable(cfgRef) && s_ff.st == HSC_SEEK_REF |-> torqueLimitEnable)
    else $error("stopper homing without torque limit");
  no_creep_end_a: assert property (s_ff.st == HSC_DECEL && pins[`HSC_PIN_STOPPED] &&
    !cfgCreep && !abortCmdSeen |=> homingEndOutput && motionEndOutput)
    else $error("homing end without creep did not close both outputs");
  creep_order_a: assert property (creepEndSeq |-> endOrderSeq)
    else $error("homing end and motion end out of order");
  creep_speed_a: assert property (s_ff.st == HSC_CREEP |-> creepSelect && moveEnable)
    else $error("slow approach not at creep speed");
endmodule

// ---- test/hsc_motion_model.sv ----
// motion hardware model answering the homing sequencer pins
`timescale 1ns/1ps
module hsc_motion_model #(
  parameter int STOP_DLY = 6,
  parameter int TRAVEL = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic moveEnable,
  input wire logic creepSelect,
  input wire logic dogAtStart,
  output logic homeDog,
  output logic stopperPressed,
  output logic motorStopped,
  output logic shiftDone
);
  int runCnt;
  int stopCnt;
  // ----------------------------------------
  // travel and stop behaviour
  // ----------------------------------------
  // the dog level is presented while idle so the start decision sees it settled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      runCnt <= 0;
      stopCnt <= 0;
      homeDog <= 1'h0;
      stopperPressed <= 1'h0;
      motorStopped <= 1'h1;
      shiftDone <= 1'h0;
    end else if (moveEnable) begin
      motorStopped <= 1'h0;
      stopCnt <= 0;
      runCnt <= runCnt + 1;
      if (runCnt == TRAVEL) begin
        homeDog <= !homeDog;
        stopperPressed <= 1'h1;
        shiftDone <= creepSelect;
      end
    end else begin
      // decel takes a while: the sequencer must wait for it
      runCnt <= 0;
      homeDog <= dogAtStart;
      stopperPressed <= 1'h0;
      shiftDone <= 1'h0;
      if (stopCnt == STOP_DLY) begin
        motorStopped <= 1'h1;
      end else begin
        stopCnt <= stopCnt + 1;
      end
    end
  end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the homing sequence controller
`timescale 1ns/1ps
`include "hsc_params.svh"
module tb;
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready, dogAtStart;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb, pulsePins;
  logic [1:0] rr;
  wire awready, wready, bvalid, arready, rvalid, homeDog, stopperPressed, motorStopped;
  wire shiftDone, motionEndOutput, homingEndOutput, moveEnable, moveCw, creepSelect;
  wire torqueLimitEnable, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] pointNumberOut;
  wire [15:0] creepSpeed;
  wire [11:0] torqueLimitValue;
  wire [6:0] obs = {irq, torqueLimitEnable, creepSelect, moveCw, moveEnable,
    motionEndOutput, homingEndOutput};
  int n_fail = 0;
  int samples_checked = 0;

  hsc_homing_ctrl i_dut (.clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .homeDog(homeDog), .encoderIndex(pulsePins[3]), .stopperPressed(stopperPressed),
    .motionSeqStart(pulsePins[0]), .pointMotionStart(pulsePins[2]),
    .pointMotionComplete(pulsePins[1]), .motorStopped(motorStopped), .shiftDone(shiftDone),
    .pointNumberOut(pointNumberOut), .motionEndOutput(motionEndOutput),
    .homingEndOutput(homingEndOutput), .moveEnable(moveEnable), .moveCw(moveCw),
    .creepSelect(creepSelect), .creepSpeed(creepSpeed),
    .torqueLimitEnable(torqueLimitEnable), .torqueLimitValue(torqueLimitValue), .irq(irq));

  hsc_motion_model i_motion (.clock(clock), .rst(rst), .moveEnable(moveEnable),
    .creepSelect(creepSelect), .dogAtStart(dogAtStart), .homeDog(homeDog),
    .stopperPressed(stopperPressed), .motorStopped(motorStopped), .shiftDone(shiftDone));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic stall;
    n_fail++;
    finish_test();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    repeat (100) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        return;
      end
    end
    stall();
  endtask

  task automatic rdt(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    repeat (100) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        rd = rdata;
        rr = rresp;
        return;
      end
    end
    stall();
  endtask

  // waits are bounded: a hung sequencer ends the run
  task automatic waitObs(input int k, input logic v);
    repeat (3000) begin
      @(posedge clock);
      if (obs[k] === v) return;
    end
    stall();
  endtask

  task automatic pulse(input int k);
    pulsePins[k] <= 1'h1;
    cyc(4);
    pulsePins[k] <= 1'h0;
    cyc(4);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic scnReset;
    chk(32'(torqueLimitValue), 32'h1F4);
    chk(32'(creepSpeed), 32'h0A);
    rdt(`HSC_OFS_CONFIG);
    chk(rd, 32'h19);
    rdt(8'h20);
    chk(32'(rr), 32'h2);
  endtask

  task automatic scnUser;
    wr(`HSC_OFS_INT_MASK, 32'h1);
    wr(`HSC_OFS_CONFIG, 32'h11);
    wr(`HSC_OFS_COMMAND, 32'h1);
    waitObs(2, 1'h1);
    rdt(`HSC_OFS_STATUS);
    chk(rd & 32'h7, 32'h3);
    pulse(3);
    waitObs(0, 1'h1);
    chk(32'(moveEnable), 32'h0);
    wr(`HSC_OFS_CONFIG, 32'h1);
    wr(`HSC_OFS_COMMAND, 32'h1);
    waitObs(0, 1'h1);
    chk(32'(motionEndOutput), 32'h1);
    waitObs(6, 1'h1);
    wr(`HSC_OFS_INT_STAT, 32'h1);
    waitObs(6, 1'h0);
  endtask

  task automatic scnDog;
    dogAtStart <= 1'h1;
    wr(`HSC_OFS_INT_MASK, 32'h0);
    wr(`HSC_OFS_CONFIG, 32'hF9);
    wr(`HSC_OFS_COMMAND, 32'h1);
    waitObs(2, 1'h1);
    chk(32'(moveCw), 32'h0);
    chk(32'(torqueLimitEnable), 32'h1);
    cyc(40);
    rdt(`HSC_OFS_STATUS);
    chk(rd & 32'h17, 32'h3);
    pulse(3);
    waitObs(4, 1'h1);
    waitObs(0, 1'h1);
    chk(32'(motionEndOutput), 32'h0);
    @(posedge clock);
    chk(32'(motionEndOutput), 32'h1);
    dogAtStart <= 1'h0;
    chk(32'(irq), 32'h0);
    rdt(`HSC_OFS_INT_STAT);
    chk(rd & 32'h1, 32'h1);
    wr(`HSC_OFS_INT_STAT, 32'h3);
  endtask

  task automatic scnStopper;
    wr(`HSC_OFS_CONFIG, 32'h25);
    wr(`HSC_OFS_COMMAND, 32'h1);
    waitObs(2, 1'h1);
    chk(32'(moveCw), 32'h1);
    chk(32'(torqueLimitEnable), 32'h1);
    waitObs(0, 1'h1);
    chk(32'(motionEndOutput), 32'h1);
    // abort mid-homing returns the sequencer to idle with motion off
    wr(`HSC_OFS_COMMAND, 32'h1);
    waitObs(2, 1'h1);
    wr(`HSC_OFS_COMMAND, 32'h2);
    chk(32'(moveEnable), 32'h0);
    rdt(`HSC_OFS_STATUS);
    chk(rd & 32'h7, 32'h0);
  endtask

  // each timing mode must ignore the two pins that belong to the others
  task automatic scnPoint;
    logic [2:0] want;
    want = 3'h0;
    for (int m = 0; m < 3; m++) begin
      wr(`HSC_OFS_CONFIG, 32'h3000 | 32'(m));
      wr(`HSC_OFS_POINT, 32'(m + 3));
      for (int k = 0; k < 3; k++) begin
        if (k != m) pulse(k);
      end
      chk(32'(pointNumberOut), 32'(want));
      pulse(m);
      want = 3'(m + 3);
      chk(32'(pointNumberOut), 32'(want));
    end
    wr(`HSC_OFS_CONFIG, 32'h1001);
    pulse(1);
    chk(32'(pointNumberOut), 32'h0);
    wr(`HSC_OFS_CONFIG, 32'h3101);
    pulse(1);
    chk(32'(pointNumberOut), 32'h0);
  endtask

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    rst = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready, dogAtStart} = 6'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    pulsePins = 4'h0;
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    scnReset();
    scnUser();
    scnDog();
    scnStopper();
    scnPoint();
    finish_test();
  end
endmodule
